// file: rtl/ocd_channel.sv
// Output compare channel top: registers, compare logic and output pin
//
// Overview of operation
// RULE_01 - Sync event clears the timer to zero
// RULE_02 - Trigger operation holds timer until trigger fires
// RULE_03 - Control two bit 7 picks trigger/sync
// RULE_04 - Source code zero: timer runs freely
// RULE_05 - Source code 31: reset at secondary match
// RULE_06 - Pulse sync output on secondary match
// RULE_07 - Mode 1: start low, rise on match
// RULE_08 - Mode 2: start high, fall on match
// RULE_09 - Mode 3: start low, toggle each match; code starts from the software init level bit
// RULE_10 - Output changes one clock after match
// RULE_11 - Timer rolls or syncs back to zero
// RULE_12 - Flag set only on real level change
// RULE_13 - Flag two clocks after output change
// RULE_14 - Reset clears output; software sets toggle level
// RULE_15 - Primary beyond period gives no event
// RULE_16 - No event while timer held in reset
// RULE_17 - Cleared primary after event keeps level
// RULE_18 - Dual modes: primary rises, secondary falls
// RULE_19 - Mode 4: one pulse, flag at fall
// RULE_20 - Rewriting mode 4 restarts the pulse
// RULE_21 - Software keeps secondary two above primary
// RULE_22 - Software disables before changing pulse values
// RULE_23 - Mode zero disables all compare activity; code still pulses sync output on secondary match
// RULE_24 - Timer advances on each selected tick
module ocd_channel
	import ocd_pkg::*;
#(
	parameter int TIMER_W = 16
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [15:0] rdData,
	input wire logic [7:0] tickSrc,
	input wire logic [31:0] syncIn,
	output logic compareOutPin,
	output logic channelIntFlag,
	output logic syncTrigOut
);
	import ocd_pkg::*;

	typedef struct packed
	{
		logic [2:0] mode;
		logic [2:0] clkSel;
		logic initLvl;
		logic trigChoice;
		logic [4:0] syncSel;
		logic [TIMER_W-1:0] pri;
		logic [TIMER_W-1:0] sec;
		logic level;
		ocd_phase_t phase;
		logic [FLAG_PIPE-1:0] flagPipe;
		logic flag;
		logic syncOut;
		logic [15:0] rdData;
	} ocd_chan_state_t;

	ocd_chan_state_t s_q;
	ocd_chan_state_t s_d;

	logic [TIMER_W-1:0] count;
	logic running;
	logic tick;
	logic syncEvt;
	logic selfMatch;
	logic priMatch;
	logic secMatch;
	logic trigClear;
	logic wrCtrl1;
	logic [2:0] newMode;
	logic restart;

	initial
	begin
		if (TIMER_W < 2 || TIMER_W > 16)
		begin
			$error("TIMER_W must lie in 2..16");
		end
	end

	// Level a mode starts from when entered
	function automatic logic startLevel(input logic [2:0] m, input logic lvl);
		logic r;
		r = 1'b0;
		if (m == MODE_CLR)
		begin
			r = 1'b1;
		end
		else if (m == MODE_TOG)
		begin
			r = lvl;
		end
		return r;
	endfunction

	// Register write decode
	function automatic logic isWrite(input logic [2:0] a);
		return wrStb && (addr == a);
	endfunction

	ocd_src_sel u_src_sel
	(
		.tickSrc(tickSrc),
		.syncIn(syncIn),
		.clkSel(s_q.clkSel),
		.syncSel(s_q.syncSel),
		.selfMatch(selfMatch),
		.tick(tick),
		.syncEvt(syncEvt)
	);

	ocd_timer #(.TIMER_W(TIMER_W)) u_timer
	(
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick),
		.syncEvt(syncEvt),
		.trigMode(s_q.trigChoice),
		.trigClear(trigClear),
		.count(count),
		.running(running)
	);

	always_comb
	begin
		// RULE_15 equality only: no event past period
		// RULE_16 no match while held
		priMatch = tick && running && (count == s_q.pri);
		secMatch = tick && running && (count == s_q.sec);
		// RULE_05 own period end
		selfMatch = secMatch;
		trigClear = isWrite(ADDR_CTRL2) && wrData[TRIG_CHOICE_BIT] && !wrData[TRIG_STAT_BIT];
		wrCtrl1 = isWrite(ADDR_CTRL1);
		newMode = wrData[MODE_LSB +: 3];
		// RULE_20 same pulse mode restarts
		restart = wrCtrl1 && ((newMode != s_q.mode) || (newMode == MODE_PULSE));
	end

	always_comb
	begin
		s_d = s_q;
		s_d.flagPipe = {s_q.flagPipe[FLAG_PIPE-2:0], 1'b0};
		// RULE_06 sync output pulse
		s_d.syncOut = secMatch;

		if (wrCtrl1)
		begin
			s_d.mode = newMode;
			s_d.clkSel = wrData[CLK_SEL_LSB +: 3];
			s_d.initLvl = wrData[INIT_LVL_BIT];
		end
		if (isWrite(ADDR_CTRL2))
		begin
			s_d.trigChoice = wrData[TRIG_CHOICE_BIT];
			s_d.syncSel = wrData[SYNC_SEL_LSB +: 5];
		end
		if (isWrite(ADDR_PRI))
		begin
			s_d.pri = wrData[TIMER_W-1:0];
		end
		if (isWrite(ADDR_SEC))
		begin
			s_d.sec = wrData[TIMER_W-1:0];
		end
		// Status flag: write one clears
		if (isWrite(ADDR_STAT) && wrData[FLAG_BIT])
		begin
			s_d.flag = 1'b0;
		end

		if (restart)
		begin
			// RULE_14 toggle start level from software
			s_d.level = startLevel(newMode, wrData[INIT_LVL_BIT]);
			s_d.phase = PH_RISE;
		end
		else if (!wrCtrl1)
		begin
			case (s_q.mode)
				// RULE_07 set on match
				MODE_SET:
				begin
					// RULE_17 no change once set
					if (priMatch && !s_q.level)
					begin
						s_d.level = 1'b1;
						s_d.flagPipe[0] = 1'b1;
					end
				end
				// RULE_08 clear on match
				MODE_CLR:
				begin
					if (priMatch && s_q.level)
					begin
						s_d.level = 1'b0;
						s_d.flagPipe[0] = 1'b1;
					end
				end
				// RULE_09 toggle each match
				MODE_TOG:
				begin
					// RULE_12 flag on level change
					if (priMatch)
					begin
						s_d.level = !s_q.level;
						s_d.flagPipe[0] = 1'b1;
					end
				end
				// RULE_18 dual compare edges
				MODE_PULSE, MODE_CONT:
				begin
					case (s_q.phase)
						PH_RISE:
						begin
							if (priMatch)
							begin
								s_d.level = 1'b1;
								s_d.phase = PH_FALL;
							end
						end
						PH_FALL:
						begin
							// RULE_19 fall and flag; pulse mode then stops, continuous mode rearms
							if (secMatch)
							begin
								s_d.level = 1'b0;
								s_d.flagPipe[0] = 1'b1;
								s_d.phase = (s_q.mode == MODE_CONT) ? PH_RISE : PH_DONE;
							end
						end
						PH_DONE:
						begin
							s_d.phase = PH_DONE;
						end
						default:
						begin
							s_d.phase = PH_RISE;
						end
					endcase
				end
				// RULE_23 disabled channel
				MODE_OFF:
				begin
					s_d.level = 1'b0;
				end
				default:
				begin
					s_d.level = s_q.level;
				end
			endcase
		end

		// RULE_13 flag two clocks later
		if (s_q.flagPipe[FLAG_PIPE-1])
		begin
			s_d.flag = 1'b1;
		end

		s_d.rdData = 16'h0000;
		if (rdStb)
		begin
			case (addr)
				ADDR_CTRL1:
				begin
					s_d.rdData[MODE_LSB +: 3] = s_q.mode;
					s_d.rdData[INIT_LVL_BIT] = s_q.initLvl;
					s_d.rdData[CLK_SEL_LSB +: 3] = s_q.clkSel;
				end
				ADDR_CTRL2:
				begin
					s_d.rdData[TRIG_CHOICE_BIT] = s_q.trigChoice;
					s_d.rdData[TRIG_STAT_BIT] = running & s_q.trigChoice;
					s_d.rdData[SYNC_SEL_LSB +: 5] = s_q.syncSel;
				end
				ADDR_PRI:
				begin
					s_d.rdData = 16'(s_q.pri);
				end
				ADDR_SEC:
				begin
					s_d.rdData = 16'(s_q.sec);
				end
				ADDR_TMR:
				begin
					s_d.rdData = 16'(count);
				end
				ADDR_STAT:
				begin
					s_d.rdData[FLAG_BIT] = s_q.flag;
				end
				default:
				begin
					s_d.rdData = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_q.mode <= RST_CTRL1[MODE_LSB +: 3];
			s_q.clkSel <= RST_CTRL1[CLK_SEL_LSB +: 3];
			s_q.initLvl <= RST_CTRL1[INIT_LVL_BIT];
			s_q.trigChoice <= RST_CTRL2[TRIG_CHOICE_BIT];
			s_q.syncSel <= RST_CTRL2[SYNC_SEL_LSB +: 5];
			s_q.pri <= RST_CMP[TIMER_W-1:0];
			s_q.sec <= RST_CMP[TIMER_W-1:0];
			// RULE_14 output logic cleared
			s_q.level <= 1'b0;
			s_q.phase <= PH_RISE;
			s_q.flagPipe <= '0;
			s_q.flag <= 1'b0;
			s_q.syncOut <= 1'b0;
			s_q.rdData <= 16'h0000;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// RULE_10 pin one clock after match
	assign compareOutPin = s_q.level;
	assign channelIntFlag = s_q.flag;
	assign syncTrigOut = s_q.syncOut;
	assign rdData = s_q.rdData;
endmodule

// file: rtl/ocd_pkg.sv
// Shared constants and types of the output compare channel
package ocd_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] ADDR_CTRL1 = 3'h0;
	localparam logic [2:0] ADDR_CTRL2 = 3'h1;
	localparam logic [2:0] ADDR_PRI = 3'h2;
	localparam logic [2:0] ADDR_SEC = 3'h3;
	localparam logic [2:0] ADDR_TMR = 3'h4;
	localparam logic [2:0] ADDR_STAT = 3'h5;
	// Field positions
	localparam int MODE_LSB = 0;
	localparam int INIT_LVL_BIT = 5;
	localparam int CLK_SEL_LSB = 10;
	localparam int SYNC_SEL_LSB = 0;
	localparam int TRIG_STAT_BIT = 6;
	localparam int TRIG_CHOICE_BIT = 7;
	localparam int FLAG_BIT = 0;
	// Reset values
	localparam logic [15:0] RST_CTRL1 = 16'h0000;
	localparam logic [15:0] RST_CTRL2 = 16'h0000;
	localparam logic [15:0] RST_CMP = 16'h0000;
	localparam logic [15:0] RST_TMR = 16'h0000;
	// Compare modes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_SET = 3'h1;
	localparam logic [2:0] MODE_CLR = 3'h2;
	localparam logic [2:0] MODE_TOG = 3'h3;
	localparam logic [2:0] MODE_PULSE = 3'h4;
	localparam logic [2:0] MODE_CONT = 3'h5;
	// Sync source codes and the clock select code that ticks every cycle
	localparam logic [4:0] SYNC_NONE = 5'h00;
	localparam logic [4:0] SYNC_SELF = 5'h1F;
	localparam logic [2:0] CLK_PERIPH = 3'h7;
	// Cycle counts: output change after match, flag after output change
	localparam int OUT_DELAY = 1;
	localparam int FLAG_DELAY = 2;
	localparam int FLAG_PIPE = OUT_DELAY + FLAG_DELAY - 1;
	typedef enum logic [1:0]
	{
		PH_RISE = 2'b00,
		PH_FALL = 2'b01,
		PH_DONE = 2'b10
	} ocd_phase_t;
endpackage

// file: rtl/ocd_src_sel.sv
// Clock tick and sync source selection
module ocd_src_sel
	import ocd_pkg::*;
(
	input wire logic [7:0] tickSrc,
	input wire logic [31:0] syncIn,
	input wire logic [2:0] clkSel,
	input wire logic [4:0] syncSel,
	input wire logic selfMatch,
	output logic tick,
	output logic syncEvt
);
	always_comb
	begin
		tick = tickSrc[clkSel] | (clkSel == CLK_PERIPH);
		// RULE_04 no sync source
		if (syncSel == SYNC_NONE)
		begin
			syncEvt = 1'b0;
		end
		// RULE_05 self sync
		else if (syncSel == SYNC_SELF)
		begin
			syncEvt = selfMatch;
		end
		else
		begin
			syncEvt = syncIn[syncSel];
		end
	end
endmodule

// file: rtl/ocd_timer.sv
// Channel timer with sync and trigger operation
module ocd_timer
	import ocd_pkg::*;
#(
	parameter int TIMER_W = 16
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic syncEvt,
	input wire logic trigMode,
	input wire logic trigClear,
	output logic [TIMER_W-1:0] count,
	output logic running
);
	typedef struct packed
	{
		logic [TIMER_W-1:0] cnt;
		logic run;
	} ocd_tmr_state_t;

	ocd_tmr_state_t s_q;
	ocd_tmr_state_t s_d;

	initial
	begin
		if (TIMER_W < 2 || TIMER_W > 16)
		begin
			$error("TIMER_W must lie in 2..16");
		end
	end

	always_comb
	begin
		s_d = s_q;
		// RULE_02 rearm the hold
		// Takes priority so that the write entering trigger operation holds at once
		if (trigClear)
		begin
			s_d.run = 1'b0;
			s_d.cnt = '0;
		end
		// RULE_03 trigger or sync
		else if (trigMode)
		begin
			// RULE_02 held until trigger
			if (!s_q.run)
			begin
				s_d.cnt = '0;
				s_d.run = syncEvt;
			end
			// RULE_24 advance on tick
			else if (tick)
			begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
		else
		begin
			s_d.run = 1'b1;
			// RULE_01 clear on sync
			// RULE_11 zero after sync
			if (syncEvt)
			begin
				s_d.cnt = '0;
			end
			else if (tick)
			begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_q.cnt <= RST_TMR[TIMER_W-1:0];
			s_q.run <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign count = s_q.cnt;
	assign running = s_q.run;
endmodule

// file: tb/ocd_channel_properties.sv
// Port checker of the output compare channel
module ocd_channel_properties
	import ocd_pkg::*;
#(
	parameter int TIMER_W = 16
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [15:0] rdData,
	input wire logic [7:0] tickSrc,
	input wire logic [31:0] syncIn,
	input wire logic compareOutPin,
	input wire logic channelIntFlag,
	input wire logic syncTrigOut
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] mode_q;
	logic [2:0] age_q;
	logic done_q;
	logic modeWr;
	assign modeWr = wrStb && addr == ADDR_CTRL1;
	// Mode shadow, cycles since a mode write, single pulse finished
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mode_q <= MODE_OFF;
			age_q <= 3'h0;
			done_q <= 1'b0;
		end
		else
		begin
			mode_q <= modeWr ? wrData[2:0] : mode_q;
			age_q <= modeWr ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
			done_q <= !modeWr && (done_q || mode_q == MODE_PULSE && age_q == 3'h7
				&& $fell(compareOutPin));
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_read_idle: assert property (!$past(rdStb) |-> rdData == 16'h0000)
		else $error("read data not zero outside a read cycle");
	chk_reset_low: assert property ($rose(rst_n) |-> !compareOutPin && !channelIntFlag)
		else $error("outputs not low after reset");
	chk_flag_cause: assert property ($rose(channelIntFlag) |->
		$past(compareOutPin, 2) != $past(compareOutPin, 3))
		else $error("flag set without a level change");
	chk_flag_delay: assert property (mode_q == MODE_SET && age_q == 3'h7
		&& $rose(compareOutPin) |-> ##2 channelIntFlag)
		else $error("flag late after output change");
	chk_off_quiet: assert property (mode_q == MODE_OFF && age_q == 3'h7 |->
		!compareOutPin && !$rose(channelIntFlag))
		else $error("activity while channel disabled");
	chk_set_holds: assert property (mode_q == MODE_SET && age_q == 3'h7
		|-> !$fell(compareOutPin))
		else $error("output fell in set mode");
	chk_clr_holds: assert property (mode_q == MODE_CLR && age_q == 3'h7
		|-> !$rose(compareOutPin))
		else $error("output rose in clear mode");
	chk_one_pulse: assert property (done_q |-> !$rose(compareOutPin))
		else $error("second pulse without mode write");
	chk_flag_sticky: assert property (channelIntFlag && !(wrStb && addr == ADDR_STAT
		&& wrData[FLAG_BIT]) |=> channelIntFlag)
		else $error("flag dropped without clear");
endmodule

// file: tb/ocd_pin_watch.sv
// Model of the circuit fed by the compare output pin
module ocd_pin_watch
(
	input wire logic clock,
	input wire logic compareOutPin,
	output int rises,
	output int lastHigh
);
	timeunit 1ns;
	timeprecision 1ns;
	int run_q = 0;
	initial
	begin
		rises = 0;
		lastHigh = 0;
	end
	// Count pulses and measure the last high time in cycles
	always @(posedge clock)
	begin
		if (compareOutPin === 1'b1)
		begin
			run_q <= run_q + 1;
			if (run_q == 0)
				rises <= rises + 1;
		end
		else
		begin
			if (run_q != 0)
				lastHigh <= run_q;
			run_q <= 0;
		end
	end
endmodule

// file: tb/output_compare_channel_single_dual_tb_top.sv
// Self-checking bench of the output compare channel
module output_compare_channel_single_dual_tb_top
	import ocd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wrData = 16'h0000;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [15:0] rdData;
	logic [7:0] tickSrc = 8'h00;
	logic [31:0] syncIn = 32'h00000000;
	logic compareOutPin;
	logic channelIntFlag;
	logic syncTrigOut;
	int miscompares = 0;
	int n_tests = 0;
	int seed = 32'h39a20969;
	int rises;
	int lastHigh;
	int t0;
	int r0;
	int k;
	logic [15:0] v;
	always #10 clock = ~clock;
	ocd_channel #(.TIMER_W(16)) dut (.clock, .rst_n, .addr, .wrData, .wrStb, .rdStb, .rdData,
		.tickSrc, .syncIn, .compareOutPin, .channelIntFlag, .syncTrigOut);
	ocd_pin_watch watch (.clock, .compareOutPin, .rises, .lastHigh);
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		#1 d = rdData;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic waitPin(input logic lv);
		for (int i = 0; i < 30 && compareOutPin !== lv; i++)
			tick(1);
		chk("pinWait", lv, compareOutPin);
		if (compareOutPin !== lv)
			end_sim();
	endtask
	initial
	begin
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		chk("pin", 0, compareOutPin);
		for (k = 0; k < 8; k++)
		begin
			rd(k[2:0], v);
			chk("reg", 0, v);
		end
		tickSrc <= $random(seed);
		wr(ADDR_CTRL1, 16'h1C00);
		tick(9);
		rd(ADDR_TMR, v);
		t0 = v;
		syncIn <= 32'hFFFFFFFF;
		wr(ADDR_TMR, 16'h1234);
		syncIn <= 32'h0;
		rd(ADDR_TMR, v);
		chk("freeRun", t0 + 2, v);
		k = 1 + {$random(seed)} % 30;
		wr(ADDR_CTRL2, 16'(k));
		tick(30);
		syncIn[k] <= 1'b1;
		tick(1);
		syncIn <= 32'h0;
		rd(ADDR_TMR, v);
		chk("syncClr", 0, v);
		wr(ADDR_CTRL2, 16'h0080 | 16'(k));
		wr(ADDR_CTRL1, 16'h1C00 | MODE_SET);
		tick(3);
		rd(ADDR_TMR, v);
		chk("held", 0, v);
		chk("heldPin", 0, compareOutPin);
		wr(ADDR_CTRL1, 16'h1C00);
		syncIn[k] <= 1'b1;
		tick(1);
		syncIn <= 32'h0;
		tick(9);
		rd(ADDR_TMR, v);
		chk("trigRun", 9, v);
		rd(ADDR_CTRL2, v);
		chk("trigStat", 1, v[TRIG_STAT_BIT]);
		wr(ADDR_SEC, 16'd20);
		wr(ADDR_CTRL2, SYNC_SELF);
		k = 0;
		repeat (63)
		begin
			tick(1);
			k += syncTrigOut;
		end
		chk("syncOut", 3, k);
		wr(ADDR_PRI, 16'd5);
		wr(ADDR_CTRL1, 16'h1C00 | MODE_SET);
		waitPin(1'b1);
		tick(3);
		chk("flag", 1, channelIntFlag);
		wr(ADDR_STAT, 16'h0001);
		wr(ADDR_PRI, 16'h0000);
		tick(42);
		chk("pinSet", 1, compareOutPin);
		chk("noFlag", 0, channelIntFlag);
		wr(ADDR_PRI, 16'd30);
		wr(ADDR_CTRL1, 16'h1C00 | MODE_CLR);
		tick(60);
		chk("pinClr", 1, compareOutPin);
		rd(ADDR_STAT, v);
		chk("flagClr", 0, v);
		wr(ADDR_PRI, 16'd5);
		waitPin(1'b0);
		tick(3);
		chk("flag", 1, channelIntFlag);
		wr(ADDR_CTRL1, 16'h1C00 | MODE_TOG);
		tick(90);
		chk("toggle", 21, lastHigh);
		for (k = 0; k < 3; k++)
		begin
			t0 = {$random(seed)} % 8;
			wr(ADDR_CTRL1, 16'h1C00);
			wr(ADDR_STAT, 16'h0001);
			wr(ADDR_PRI, 16'(t0));
			wr(ADDR_SEC, 16'(t0 + 2 + k * 5));
			// Restart the timer from zero so it lies below the new period
			wr(ADDR_CTRL2, 16'h0080);
			wr(ADDR_CTRL2, 16'(SYNC_SELF));
			r0 = rises;
			wr(ADDR_CTRL1, 16'h1C00 | MODE_PULSE);
			tick(80);
			chk("pulses", r0 + 1, rises);
			chk("width", 2 + k * 5, lastHigh);
			chk("flag", 1, channelIntFlag);
		end
		wr(ADDR_CTRL1, 16'h1C00 | MODE_PULSE);
		tick(40);
		chk("again", r0 + 2, rises);
		wr(ADDR_CTRL1, 16'h1C00);
		wr(ADDR_STAT, 16'h0001);
		tick(50);
		chk("offPin", 0, compareOutPin);
		chk("offFlag", 0, channelIntFlag);
		end_sim();
	end
endmodule
bind ocd_channel ocd_channel_properties #(.TIMER_W(TIMER_W)) props (.clock, .rst_n, .addr,
	.wrData, .wrStb, .rdStb, .rdData, .tickSrc, .syncIn, .compareOutPin, .channelIntFlag,
	.syncTrigOut);
